// ### plpc_regs.vh
`ifndef PLPC_REGS_VH
`define PLPC_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address on the bus is four times these)
// ----------------------------------------------------------------
`define PLPC_IDX_LATCH0   16'hFF00
`define PLPC_IDX_DIR0     16'hFF20
`define PLPC_IDX_BITOP    16'hFFF0
`define PLPC_IDX_PULLUP   16'hFFF7
`define PLPC_NUM_PORTS    6

// ----------------------------------------------------------------
// bus address layout
// ----------------------------------------------------------------
`define PLPC_ADDR_W       18
`define PLPC_IDX_LSB      2
`define PLPC_ALIGN_ZERO   2'h0

// ----------------------------------------------------------------
// reset values and implemented-bit masks (port 0 in the low byte)
// ----------------------------------------------------------------
`define PLPC_PULLUP_RST   8'h00
`define PLPC_PULLUP_MASK  8'h3F
`define PLPC_DIR_RST      48'hFFFFFFFFFFFF
`define PLPC_LATCH_RST    48'h000000000000
`define PLPC_PORT_MASK    48'h0FFF0707FFFF

// ----------------------------------------------------------------
// bit operation register fields
// ----------------------------------------------------------------
`define PLPC_BITOP_NUM    2:0
`define PLPC_BITOP_VAL    3
`define PLPC_BITOP_TGL    4
`define PLPC_BITOP_TGT    31:16

`endif

// ### plpc_sync.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-flop synchroniser for asynchronous pin levels
// ----------------------------------------------------------------
module plpc_sync #(
  parameter W = 48
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // levels
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] meta;

  // first stage feeds only the second stage
  always @(posedge clk) begin
    if (rst) begin
      meta <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // plpc_sync

// ### plpc_pad.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// one port of pad control: drive, enable and pull-up per bit
// ----------------------------------------------------------------
module plpc_pad (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // port state
  input  wire [7:0] latch,
  input  wire [7:0] dir,
  input  wire [7:0] mask,
  input  wire       pu_sel,
  // alternate function output
  input  wire [7:0] alt_en,
  input  wire [7:0] alt_val,
  // pad controls
  output reg  [7:0] pad_out,
  output reg  [7:0] pad_oe,
  output reg  [7:0] pad_pu
);

  wire [7:0] drive_latch;
  wire [7:0] next_oe;
  wire [7:0] next_pu;

  // buffer on for output mode (dir 0) or an active alternate output
  assign drive_latch = ~dir & mask;
  assign next_oe     = (drive_latch | alt_en) & mask;
  // pull-up only on plain inputs of a selected port
  assign next_pu     = {8{pu_sel}} & dir & ~alt_en & mask;

  // registered so the top outputs come straight from flops
  always @(posedge clk) begin
    if (rst) begin
      pad_out <= 8'h00;
      pad_oe  <= 8'h00;
      pad_pu  <= 8'h00;
    end else begin
      pad_out <= ((alt_en & alt_val) | (~alt_en & latch)) & mask;
      pad_oe  <= next_oe;
      pad_pu  <= next_pu;
    end
  end

endmodule // plpc_pad

// ### plpc_top.v
//
// Contract
// - pull-up only when port selected and bit input
// - no pull-up on output-mode bits
// - no pull-up on alternate-function output pins
// - pull-up option at FFF7, reset to 00
// - bits 0-5 select pull-ups, 6-7 read zero
// - pull-up option takes bit and byte writes
// - output mode: latch written and driven out
// - latch holds until next write
// - input mode: latch written, pin undriven
// - bit operations run as full byte accesses
// - output-mode read returns latch, latch kept
// - input-mode read returns pin, latch kept
// - output-mode modify writes latch and drives pin
// - input-mode modify: latch undefined, pin undriven
// - direction 0 output, 1 input, reset FF
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "plpc_regs.vh"

module plpc_top (
  // clock and reset
  input  wire                    REF_CLK,
  input  wire                    SYS_RST,
  // apb slave
  input  wire                    PSEL,
  input  wire                    PENABLE,
  input  wire                    PWRITE,
  input  wire [`PLPC_ADDR_W-1:0] PADDR,
  input  wire [31:0]             PWDATA,
  input  wire [3:0]              PSTRB,
  output reg  [31:0]             PRDATA,
  output reg                     PREADY,
  output reg                     PSLVERR,
  // pins, port m in bits 8m+7..8m
  input  wire [47:0]             PIN_IN,
  output wire [47:0]             PIN_OUT,
  output wire [47:0]             PIN_OE,
  output wire [47:0]             PIN_PULLUP,
  // alternate function outputs from on-chip peripherals
  input  wire [47:0]             ALT_OUT_EN,
  input  wire [47:0]             ALT_OUT
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [47:0] latch;
  reg  [47:0] dir;
  reg  [7:0]  pullup_option_reg;
  wire [47:0] pin_s;
  wire [47:0] port_rd;
  wire [15:0] idx;
  wire [15:0] tgt;
  wire [2:0]  bit_num;
  wire [7:0]  cur_rd;
  wire        cur_ok;
  wire [7:0]  tgt_rd;
  wire        tgt_ok;
  wire        is_bitop;
  wire        aligned;
  reg  [7:0]  bit_mod;
  reg  [15:0] wr_idx;
  reg  [7:0]  wr_data;
  reg         next_err;
  wire        wr_fire;

  // constant views, so each port takes its own byte slice
  localparam [47:0] port_mask = `PLPC_PORT_MASK;
  localparam [47:0] dir_rst   = `PLPC_DIR_RST;
  localparam [47:0] latch_rst = `PLPC_LATCH_RST;

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  plpc_sync #(
    .W (48)
  ) u_sync (
    .clk  (REF_CLK),
    .rst  (SYS_RST),
    .din  (PIN_IN),
    .dout (pin_s)
  );

  // port read value: pin for inputs, latch for outputs
  assign port_rd = ((dir & pin_s) | (~dir & latch)) & `PLPC_PORT_MASK;

  // ----------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------
  // state comes in as arguments: a continuous assign only wakes up on
  // its operands, so reading module state inside would go stale
  function [8:0] rd_reg;
    input [15:0] i;
    input [47:0] prd;
    input [47:0] d;
    input [7:0]  pu;
    integer m;
    begin
      rd_reg = 9'h000;
      for (m = 0; m < `PLPC_NUM_PORTS; m = m + 1) begin
        if (i == `PLPC_IDX_LATCH0 + m[15:0]) begin
          rd_reg = {1'b1, prd[8*m +: 8]};
        end
        if (i == `PLPC_IDX_DIR0 + m[15:0]) begin
          rd_reg = {1'b1, d[8*m +: 8]};
        end
      end
      if (i == `PLPC_IDX_PULLUP) begin
        rd_reg = {1'b1, pu & `PLPC_PULLUP_MASK};
      end
    end
  endfunction

  assign idx      = PADDR[`PLPC_ADDR_W-1:`PLPC_IDX_LSB];
  assign aligned  = (PADDR[`PLPC_IDX_LSB-1:0] == `PLPC_ALIGN_ZERO);
  assign is_bitop = (idx == `PLPC_IDX_BITOP);
  assign tgt      = PWDATA[`PLPC_BITOP_TGT];
  assign bit_num  = PWDATA[`PLPC_BITOP_NUM];
  assign {cur_ok, cur_rd} = rd_reg(idx, port_rd, dir, pullup_option_reg);
  assign {tgt_ok, tgt_rd} = rd_reg(tgt, port_rd, dir, pullup_option_reg);

  // ----------------------------------------------------------------
  // bit operation: whole byte is read, one bit changed, byte written
  // ----------------------------------------------------------------
  // input bits of a port byte take the pin level back into the latch,
  // which is why untouched input latches are not preserved
  always @* begin
    bit_mod = tgt_rd;
    if (PWDATA[`PLPC_BITOP_TGL]) begin
      bit_mod[bit_num] = ~tgt_rd[bit_num];
    end else begin
      bit_mod[bit_num] = PWDATA[`PLPC_BITOP_VAL];
    end
  end

  // one write path for byte and bit writes
  always @* begin
    if (is_bitop) begin
      wr_idx  = tgt;
      wr_data = bit_mod;
    end else begin
      wr_idx  = idx;
      wr_data = PWDATA[7:0];
    end
  end

  // error: misaligned, unmapped, or a bit operation on a bad target
  always @* begin
    if (!aligned) begin
      next_err = 1'b1;
    end else if (is_bitop) begin
      next_err = PWRITE ? !tgt_ok : 1'b0;
    end else begin
      next_err = !cur_ok;
    end
  end

  // ----------------------------------------------------------------
  // apb answer: ready in the first access cycle
  // ----------------------------------------------------------------
  // registering the answer from the setup cycle costs no wait state and keeps outputs clean
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PSLVERR <= PSEL & ~PENABLE & next_err;
      if (PSEL && !PENABLE && !PWRITE && cur_ok && aligned) begin
        PRDATA <= {24'h000000, cur_rd};
      end else if (PSEL && !PENABLE) begin
        PRDATA <= 32'h00000000;
      end
    end
  end

  assign wr_fire = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR & PSTRB[0];

  // ----------------------------------------------------------------
  // register writes, one edge per access
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `PLPC_NUM_PORTS; g = g + 1) begin : g_port
      localparam [15:0] lat_idx = `PLPC_IDX_LATCH0 + g;
      localparam [15:0] dir_idx = `PLPC_IDX_DIR0 + g;
      always @(posedge REF_CLK) begin
        if (SYS_RST) begin
          latch[8*g +: 8] <= latch_rst[8*g +: 8];
          dir[8*g +: 8]   <= dir_rst[8*g +: 8];
        end else if (wr_fire) begin
          if (wr_idx == lat_idx) begin
            // latch written whatever the direction; others hold
            latch[8*g +: 8] <= wr_data & port_mask[8*g +: 8];
          end
          if (wr_idx == dir_idx) begin
            // unimplemented direction bits stay at input
            dir[8*g +: 8] <= wr_data | ~port_mask[8*g +: 8];
          end
        end
      end

      plpc_pad u_pad (
        .clk     (REF_CLK),
        .rst     (SYS_RST),
        .latch   (latch[8*g +: 8]),
        .dir     (dir[8*g +: 8]),
        .mask    (port_mask[8*g +: 8]),
        .pu_sel  (pullup_option_reg[g]),
        .alt_en  (ALT_OUT_EN[8*g +: 8]),
        .alt_val (ALT_OUT[8*g +: 8]),
        .pad_out (PIN_OUT[8*g +: 8]),
        .pad_oe  (PIN_OE[8*g +: 8]),
        .pad_pu  (PIN_PULLUP[8*g +: 8])
      );
    end
  endgenerate

  // pull-up option register; bits 7..6 never store
  always @(posedge REF_CLK) begin
    if (SYS_RST) begin
      pullup_option_reg <= `PLPC_PULLUP_RST;
    end else if (wr_fire && wr_idx == `PLPC_IDX_PULLUP) begin
      pullup_option_reg <= wr_data & `PLPC_PULLUP_MASK;
    end
  end

endmodule // plpc_top

// ### plpc_pins.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// board model: pin level seen by the port logic
// ----------------------------------------------------------------
module plpc_pins (
  // pad controls from the port logic
  input  wire [47:0] pad_out,
  input  wire [47:0] pad_oe,
  input  wire [47:0] pad_pu,
  // board drivers
  input  wire [47:0] board,
  input  wire [47:0] board_en,
  // resulting level
  output wire [47:0] pin_lvl
);
  // own drive wins, then the board, then the pull-up; a floating pin
  // shows the inverse of the latch so a stale value never reads back
  assign pin_lvl = (pad_oe & pad_out) | (~pad_oe & board_en & board)
                 | (~pad_oe & ~board_en & (pad_pu | ~pad_out));
endmodule // plpc_pins

// ### plpc_top_chk.sv
`timescale 1ns/1ps
`include "plpc_regs.vh"

// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module plpc_chk (
  // clock and reset
  input  wire                    REF_CLK,
  input  wire                    SYS_RST,
  // apb
  input  wire                    PSEL,
  input  wire                    PENABLE,
  input  wire                    PWRITE,
  input  wire [`PLPC_ADDR_W-1:0] PADDR,
  input  wire [31:0]             PRDATA,
  input  wire                    PREADY,
  input  wire                    PSLVERR,
  // pins
  input  wire [47:0]             PIN_OUT,
  input  wire [47:0]             PIN_OE,
  input  wire [47:0]             PIN_PULLUP,
  input  wire [47:0]             ALT_OUT_EN,
  input  wire [47:0]             ALT_OUT
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_acc; PSEL && PENABLE && PREADY; endsequence
  property p_ready; s_setup |=> PREADY; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_one; s_acc |=> !PREADY; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err; s_setup ##0 (PADDR[1:0] != 2'h0) |=> PSLVERR; endproperty
  a_err: assert property (p_err) else $error("misaligned not refused");
  property p_errq; PSLVERR |-> PREADY; endproperty
  a_errq: assert property (p_errq) else $error("error without ready");
  property p_hi; s_acc and !PWRITE |-> PRDATA[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read bits set");
  property p_pull;
    s_acc and (!PWRITE && PADDR == {`PLPC_IDX_PULLUP, 2'h0}) |-> PRDATA[7:6] == 2'h0;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up option bits 7:6 set");
  property p_oepu; (PIN_OE & PIN_PULLUP) == 48'h0; endproperty
  a_oepu: assert property (p_oepu) else $error("pull-up on driven bit");
  property p_alt; (PIN_PULLUP & $past(ALT_OUT_EN)) == 48'h0; endproperty
  a_alt: assert property (p_alt) else $error("pull-up on alternate output");
  property p_rst;
    $past(SYS_RST, 2) && !$past(SYS_RST) |-> PIN_PULLUP == 48'h0
      && (PIN_OE & ~$past(ALT_OUT_EN)) == 48'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("pins active after reset");
  // pads lag the registers by one edge: a write one cycle back may still move them
  property p_hold;
    !$past(SYS_RST) && !$past(PSEL && PENABLE && PREADY && PWRITE) && $stable(ALT_OUT_EN)
      && $stable(ALT_OUT) |=> $stable(PIN_OUT) && $stable(PIN_OE);
  endproperty
  a_hold: assert property (p_hold) else $error("pin moved without write");
endmodule // plpc_chk

bind plpc_top plpc_chk u_chk (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP),
  .ALT_OUT_EN(ALT_OUT_EN), .ALT_OUT(ALT_OUT));

// ### plpc_top_tb.sv
`timescale 1ns/1ps
`include "plpc_regs.vh"

module plpc_top_tb;
  // ----------------------------------------------------------------
  // stimulus and observation
  // ----------------------------------------------------------------
  localparam [17:0] ad_pull = {`PLPC_IDX_PULLUP, 2'h0};
  localparam [17:0] ad_lat = {`PLPC_IDX_LATCH0, 2'h0};
  localparam [17:0] ad_dir = {`PLPC_IDX_DIR0, 2'h0};
  localparam [17:0] ad_bit = {`PLPC_IDX_BITOP, 2'h0};
  reg          REF_CLK = 1'b0;
  reg          SYS_RST = 1'b1;
  reg          PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  reg  [17:0]  PADDR = 18'h0;
  reg  [31:0]  PWDATA = 32'h0;
  reg  [3:0]   PSTRB = 4'hF;
  reg  [47:0]  ALT_OUT_EN = 48'h0, ALT_OUT = 48'h0;
  reg  [47:0]  board = 48'h30, board_en = 48'hF0;
  wire [31:0]  PRDATA;
  wire         PREADY, PSLVERR;
  wire [47:0]  PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP;
  logic [31:0] rd;
  logic        err;
  int          n_errors = 0, tests_run = 0;

  always #5 REF_CLK = ~REF_CLK;

  plpc_top dut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP), .ALT_OUT_EN(ALT_OUT_EN), .ALT_OUT(ALT_OUT));
  plpc_pins u_pins (.pad_out(PIN_OUT), .pad_oe(PIN_OE), .pad_pu(PIN_PULLUP),
    .board(board), .board_en(board_en), .pin_lvl(PIN_IN));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_of_test;
    if (n_errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] wd);
    int n;
    @(posedge REF_CLK);
    PSEL <= 1'b1; PWRITE <= wr; PADDR <= a; PWDATA <= wd;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 16);
    rd = PRDATA;
    err = PSLVERR;
    if (PREADY !== 1'b1) begin
      n_errors++;
      end_of_test();
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic rdchk(input string what, input logic [17:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, {16'h0, exp}, {16'h0, rd});
  endtask
  // pad flop plus two sync stages
  task automatic settle;
    repeat (3) @(posedge REF_CLK);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge REF_CLK);
    SYS_RST <= 1'b0;
    rdchk("pull_rst", ad_pull, 32'h0);
    rdchk("dir0_rst", ad_dir, 32'hFF);
    rdchk("dir2_rst", ad_dir + 18'h8, 32'hFF);
    chk("oe_rst", 48'h0, PIN_OE);
    chk("pu_rst", 48'h0, PIN_PULLUP);
    apb(1'b1, ad_pull, 32'hFF);
    rdchk("pull_rw", ad_pull, 32'h3F);
    settle;
    chk("pu_in", `PLPC_PORT_MASK, PIN_PULLUP);
    rdchk("p1_pulled", ad_lat + 18'h4, 32'hFF);
    // direction 0 is output: low nibble driven, high nibble read from the board
    apb(1'b1, ad_dir, 32'hF0);
    apb(1'b1, ad_lat, 32'hA5);
    settle;
    chk("oe_mix", 48'h0F, PIN_OE);
    chk("out_mix", 48'hA5, PIN_OUT & 48'hFF);
    chk("pu_mix", 48'h0FFF0707FFF0, PIN_PULLUP);
    rdchk("rd_mix", ad_lat, 32'h35);
    // set bit 1: input bits of the byte take the pin level
    apb(1'b1, ad_bit, {`PLPC_IDX_LATCH0, 16'h0009});
    apb(1'b1, ad_dir, 32'h00);
    settle;
    chk("out_bitop", 48'h37, PIN_OUT & 48'hFF);
    apb(1'b1, ad_bit, {`PLPC_IDX_LATCH0, 16'h0011});
    rdchk("rd_tgl", ad_lat, 32'h35);
    settle;
    chk("out_tgl", 48'h35, PIN_OUT & 48'hFF);
    ALT_OUT_EN <= 48'h100;
    ALT_OUT <= 48'h100;
    settle;
    chk("alt_pu", 48'h0, PIN_PULLUP & 48'h100);
    chk("alt_out", 48'h100, PIN_OE & PIN_OUT & 48'h100);
    apb(1'b1, ad_pull | 18'h1, 32'h0);
    chk("misalign", 48'h1, {47'h0, err});
    apb(1'b0, 18'h048D0, 32'h0);
    chk("unmapped", 48'h1, {47'h0, err});
    PSTRB <= 4'h0;
    apb(1'b1, ad_pull, 32'h0);
    PSTRB <= 4'hF;
    rdchk("strb_off", ad_pull, 32'h3F);
    apb(1'b1, ad_pull, 32'h0);
    settle;
    chk("pu_off", 48'h0, PIN_PULLUP);
    end_of_test();
  end
endmodule // plpc_top_tb
